/* design/ebws_pkg.sv */
// constants and state types for the external bus burst, wait and suspend block
package ebws_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 64;
	localparam int BANK_W = 4;
	localparam int BANK_SEL_W = 2;
	localparam int ID_W = 3;
	// keeper enabled when identifier matches 00x
	localparam logic [2:0] KEEP_ID_MASK = 3'h6;
	localparam logic [2:0] KEEP_ID_VALUE = 3'h0;
	localparam logic [31:0] ADDR_STEP = 32'h0000_0001;
	localparam logic [31:0] ADDR_RST = 32'h0000_0000;
	localparam logic [63:0] DATA_RST = 64'h0;
	localparam logic [3:0] BANK_IDLE = 4'hf;
	localparam logic [3:0] BANK_ONE = 4'h1;
	localparam logic PIN_IDLE = 1'b1;

	typedef enum logic [2:0] {
		EBWS_M_IDLE = 3'b001,
		EBWS_M_XFER = 3'b010,
		EBWS_M_LOAD = 3'b100
	} ebws_mstate_t;

	typedef enum logic [2:0] {
		EBWS_S_IDLE = 3'b001,
		EBWS_S_WAIT = 3'b010,
		EBWS_S_ACK = 3'b100
	} ebws_sstate_t;
endpackage

/* design/ebws_keep_if.sv */
// one input pin with its keeper enable and registered level
`timescale 1ns/10ps
interface ebws_keep_if;
	logic pin;
	logic driven;
	logic enable;
	logic level;
	modport keeper (input pin, input driven, input enable, output level);
	modport user (output pin, output driven, output enable, input level);
endinterface

/* design/ebws_keeper.sv */
// input sampler with optional bus-hold behaviour
`timescale 1ns/10ps
module ebws_keeper (
	input wire logic clk_sys,
	input wire logic rst_n,
	ebws_keep_if.keeper kp
);
	logic level_reg;
	logic level_next;

	always_comb begin
		level_next = kp.pin;
		if (kp.enable && !kp.driven) begin
			level_next = level_reg; // RULE6
		end
	end

	// sampled on the rising edge; all decisions use this copy
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			level_reg <= ebws_pkg::PIN_IDLE;
		end else begin
			level_reg <= level_next; // RULE13
		end
	end

	assign kp.level = level_reg;
endmodule // ebws_keeper

/* design/ebws_port.sv */
// external bus port: burst sequencing, wait states and bus suspend
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: the bus master drives burst low while consecutive-address data is moving.
// RULE2: a slave captures only the first address, then counts after each transfer.
// RULE3: the master holds the first address; increments never appear on the bus.
// RULE4: on a host burst read the device keeps counting while burst stays low.
// RULE5: burst goes low after the first access and is high on the final request.
// RULE6: identifier 00x enables keepers holding burst and acknowledge when undriven.
// RULE7: a low acknowledge stretches the device's own access until it returns high.
// RULE8: on a host synchronous access the device drives acknowledge low to wait.
// RULE9: sampled suspend floats address, data, selects and strobes the next cycle.
// RULE10: an access attempted under suspend stalls until suspend is released.
// RULE11: outside logic should use suspend only for deadlock recovery or DRAM control.
// RULE12: in synchronous mode the bank select lifts after acknowledge is seen high.
// RULE13: acknowledge and suspend are registered on the rising clock edge.
module ebws_port (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [2:0] multiproc_identifier,
	input wire logic suspend_bus_hiz_n,
	input wire logic core_req,
	input wire logic core_write,
	input wire logic core_last,
	input wire logic core_sync,
	input wire logic [1:0] core_bank,
	input wire logic [31:0] core_addr,
	input wire logic [63:0] core_wdata,
	output logic core_done,
	output logic core_stall,
	output logic [63:0] core_rdata,
	input wire logic host_sel,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [63:0] mem_wdata,
	input wire logic mem_ready,
	input wire logic [63:0] mem_rdata,
	input wire logic [31:0] addr_i,
	output logic [31:0] addr_o,
	output logic addr_oe,
	input wire logic [63:0] data_i,
	output logic [63:0] data_o,
	output logic data_oe,
	output logic [3:0] bank_select_n,
	output logic bank_select_oe,
	input wire logic read_strobe_n_i,
	output logic read_strobe_n_o,
	output logic read_strobe_oe,
	input wire logic write_strobe_n_i,
	output logic write_strobe_n_o,
	output logic write_strobe_oe,
	input wire logic burst_continue_n_i,
	input wire logic burst_driven,
	output logic burst_continue_n_o,
	output logic burst_continue_oe,
	input wire logic ack_i,
	input wire logic ack_driven,
	output logic ack_o,
	output logic ack_oe
);
	logic rst_meta_reg;
	logic rst_n;
	logic strap_done_reg;
	logic keep_en_reg;
	logic susp_n_reg;
	logic rd_q_reg;
	logic wr_q_reg;
	logic [31:0] addr_q_reg;
	logic [63:0] data_q_reg;
	logic burst_seen_reg;
	logic strobe_live_reg;
	logic m_drive;
	logic s_strobe;
	logic s_burst;
	ebws_pkg::ebws_mstate_t m_state_reg;
	ebws_pkg::ebws_sstate_t s_state_reg;
	ebws_keep_if burst_kp ();
	ebws_keep_if ack_kp ();

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// identifier is a strap, caught once after reset release
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strap_done_reg <= 1'b0;
			keep_en_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			keep_en_reg <= (multiproc_identifier & ebws_pkg::KEEP_ID_MASK) ==
				ebws_pkg::KEEP_ID_VALUE; // RULE6
		end
	end

	assign burst_kp.pin = burst_continue_n_i;
	assign burst_kp.driven = burst_driven;
	assign burst_kp.enable = keep_en_reg;
	assign ack_kp.pin = ack_i;
	assign ack_kp.driven = ack_driven;
	assign ack_kp.enable = keep_en_reg;

	ebws_keeper u_burst_keep (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.kp(burst_kp)
	);

	ebws_keeper u_ack_keep (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.kp(ack_kp)
	);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			susp_n_reg <= 1'b1;
			rd_q_reg <= 1'b0;
			wr_q_reg <= 1'b0;
			addr_q_reg <= ebws_pkg::ADDR_RST;
			data_q_reg <= ebws_pkg::DATA_RST;
		end else begin
			susp_n_reg <= suspend_bus_hiz_n; // RULE13
			rd_q_reg <= !read_strobe_n_i;
			wr_q_reg <= !write_strobe_n_i;
			addr_q_reg <= addr_i;
			data_q_reg <= data_i;
		end
	end

	// master side: the device's core reaching external memory
	assign m_drive = (m_state_reg != ebws_pkg::EBWS_M_IDLE);

	// ack only counts once it was sampled while our strobe stood on the pin
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strobe_live_reg <= 1'b0;
		end else begin
			strobe_live_reg <= (read_strobe_oe && !read_strobe_n_o) ||
				(write_strobe_oe && !write_strobe_n_o); // RULE7
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			m_state_reg <= ebws_pkg::EBWS_M_IDLE;
			core_done <= 1'b0;
			core_stall <= 1'b0;
			core_rdata <= ebws_pkg::DATA_RST;
			addr_o <= ebws_pkg::ADDR_RST;
			bank_select_n <= ebws_pkg::BANK_IDLE;
			read_strobe_n_o <= 1'b1;
			write_strobe_n_o <= 1'b1;
			burst_continue_n_o <= 1'b1;
		end else begin
			core_done <= 1'b0;
			core_stall <= 1'b0;
			case (m_state_reg)
				ebws_pkg::EBWS_M_IDLE: begin
					if (core_req && !susp_n_reg) begin
						core_stall <= 1'b1; // RULE10
					end else if (core_req && s_state_reg == ebws_pkg::EBWS_S_IDLE) begin
						addr_o <= core_addr;
						bank_select_n <= ~(ebws_pkg::BANK_ONE << core_bank);
						read_strobe_n_o <= core_write;
						write_strobe_n_o <= !core_write;
						burst_continue_n_o <= 1'b1; // RULE5
						m_state_reg <= ebws_pkg::EBWS_M_XFER;
					end
				end
				ebws_pkg::EBWS_M_XFER: begin
					if (!susp_n_reg) begin
						core_stall <= 1'b1; // RULE10
					end else if (ack_kp.level && strobe_live_reg) begin // RULE7
						core_done <= 1'b1;
						core_rdata <= data_q_reg;
						read_strobe_n_o <= 1'b1;
						write_strobe_n_o <= 1'b1;
						if (core_sync) begin
							bank_select_n <= ebws_pkg::BANK_IDLE; // RULE12
						end
						if (core_last) begin
							bank_select_n <= ebws_pkg::BANK_IDLE;
							burst_continue_n_o <= 1'b1;
							m_state_reg <= ebws_pkg::EBWS_M_IDLE;
						end else begin
							burst_continue_n_o <= 1'b0; // RULE1
							m_state_reg <= ebws_pkg::EBWS_M_LOAD;
						end
					end
				end
				ebws_pkg::EBWS_M_LOAD: begin
					// address held from the first access
					if (!core_req) begin // RULE3
						bank_select_n <= ebws_pkg::BANK_IDLE;
						burst_continue_n_o <= 1'b1;
						m_state_reg <= ebws_pkg::EBWS_M_IDLE;
					end else if (!susp_n_reg) begin
						core_stall <= 1'b1; // RULE10
					end else begin
						read_strobe_n_o <= core_write;
						write_strobe_n_o <= !core_write;
						burst_continue_n_o <= core_last; // RULE5
						m_state_reg <= ebws_pkg::EBWS_M_XFER;
					end
				end
				default: m_state_reg <= ebws_pkg::EBWS_M_IDLE;
			endcase
		end
	end

	// output enables drop the cycle after suspend is sampled low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			addr_oe <= 1'b0;
			bank_select_oe <= 1'b0;
			read_strobe_oe <= 1'b0;
			write_strobe_oe <= 1'b0;
			burst_continue_oe <= 1'b0;
		end else begin
			addr_oe <= m_drive && susp_n_reg; // RULE9
			bank_select_oe <= m_drive && susp_n_reg;
			read_strobe_oe <= m_drive && susp_n_reg;
			write_strobe_oe <= m_drive && susp_n_reg;
			burst_continue_oe <= m_drive && susp_n_reg;
		end
	end

	// slave side: a host reaching internal memory
	assign s_strobe = host_sel && (rd_q_reg || wr_q_reg) && !m_drive;
	assign s_burst = !burst_kp.level;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_state_reg <= ebws_pkg::EBWS_S_IDLE;
			burst_seen_reg <= 1'b0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= ebws_pkg::ADDR_RST;
			mem_wdata <= ebws_pkg::DATA_RST;
			ack_o <= 1'b1;
			ack_oe <= 1'b0;
		end else begin
			case (s_state_reg)
				ebws_pkg::EBWS_S_IDLE: begin
					ack_oe <= 1'b0;
					if (s_strobe) begin
						mem_addr <= addr_q_reg; // RULE2
						mem_we <= wr_q_reg;
						mem_wdata <= data_q_reg;
						mem_req <= 1'b1;
						burst_seen_reg <= s_burst;
						ack_o <= 1'b0; // RULE8
						ack_oe <= 1'b1;
						s_state_reg <= ebws_pkg::EBWS_S_WAIT;
					end
				end
				ebws_pkg::EBWS_S_WAIT: begin
					if (s_burst) begin
						burst_seen_reg <= 1'b1;
					end
					if (mem_ready) begin
						mem_req <= 1'b0;
						ack_o <= 1'b1;
						s_state_reg <= ebws_pkg::EBWS_S_ACK;
					end
				end
				ebws_pkg::EBWS_S_ACK: begin
					if (s_strobe && (burst_seen_reg || s_burst)) begin
						mem_addr <= mem_addr + ebws_pkg::ADDR_STEP; // RULE4
						mem_we <= wr_q_reg;
						mem_wdata <= data_q_reg;
						mem_req <= 1'b1;
						burst_seen_reg <= s_burst;
						ack_o <= 1'b0; // RULE8
						s_state_reg <= ebws_pkg::EBWS_S_WAIT;
					end else begin
						ack_oe <= 1'b0;
						s_state_reg <= ebws_pkg::EBWS_S_IDLE;
					end
				end
				default: s_state_reg <= ebws_pkg::EBWS_S_IDLE;
			endcase
		end
	end

	// read data goes out once memory has answered a host read
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			data_o <= ebws_pkg::DATA_RST;
			data_oe <= 1'b0;
		end else if (m_drive) begin
			data_o <= core_wdata;
			data_oe <= !core_write ? 1'b0 : susp_n_reg; // RULE9
		end else if (s_state_reg == ebws_pkg::EBWS_S_WAIT && mem_ready && !mem_we) begin
			data_o <= mem_rdata;
			data_oe <= susp_n_reg;
		end else if (s_state_reg != ebws_pkg::EBWS_S_ACK || !susp_n_reg) begin
			data_oe <= 1'b0;
		end
	end
endmodule // ebws_port

/* tb/ebws_port_assertions.sv */
// assertions on the external bus port pins
`timescale 1ns/10ps
module ebws_port_assertions (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic suspend_bus_hiz_n,
	input wire logic core_sync,
	input wire logic core_done,
	input wire logic host_sel,
	input wire logic mem_req,
	input wire logic mem_ready,
	input wire logic ack_i,
	input wire logic ack_o,
	input wire logic ack_oe,
	input wire logic [31:0] addr_o,
	input wire logic addr_oe,
	input wire logic data_oe,
	input wire logic bank_select_oe,
	input wire logic [3:0] bank_select_n,
	input wire logic read_strobe_n_o,
	input wire logic read_strobe_oe,
	input wire logic write_strobe_n_o,
	input wire logic write_strobe_oe,
	input wire logic burst_continue_n_o
);
	logic strb_act;
	assign strb_act = !(read_strobe_n_o && write_strobe_n_o);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence s_susp;
		!suspend_bus_hiz_n [*4];
	endsequence
	a_susp_hiz: assert property (!suspend_bus_hiz_n |-> ##2
		!(addr_oe || data_oe || bank_select_oe || read_strobe_oe || write_strobe_oe))
		else $error("bus driven under suspend");
	a_susp_halt: assert property (s_susp |-> !core_done)
		else $error("done under suspend");
	a_ack_wait: assert property (!ack_i [*2] |=> !core_done)
		else $error("done while ack low");
	a_burst_after: assert property ($fell(burst_continue_n_o) |->
		$past(strb_act) || $past(strb_act, 2)) else $error("burst before access");
	a_addr_hold: assert property (!burst_continue_n_o && $past(addr_oe) |->
		$stable(addr_o)) else $error("address moved in burst");
	a_host_wait: assert property (host_sel && mem_req |-> ack_oe && !ack_o)
		else $error("no wait on host access");
	a_ack_release: assert property (host_sel && mem_req && mem_ready |=>
		ack_o && ack_oe) else $error("ack not released");
	a_sync_lift: assert property (core_sync && core_done |=> bank_select_n == 4'hf)
		else $error("select not lifted");
endmodule // ebws_port_assertions
bind ebws_port ebws_port_assertions u_chk (.*);

/* tb/ebws_ext_mem.sv */
// external memory: wait states and its own address counter
`timescale 1ns/10ps
module ebws_ext_mem (
	input wire logic clk_sys,
	input wire logic [3:0] waits,
	input wire logic strobe_n,
	input wire logic burst_n,
	input wire logic [31:0] addr,
	output logic ack,
	output logic [63:0] rdata
);
	logic [3:0] wcnt_reg;
	logic [31:0] cnt_reg;
	logic act_reg;
	logic in_burst_reg = 1'b0;
	logic first;
	// only the opening beat of a burst takes the address from the bus
	assign first = !strobe_n && !act_reg && !in_burst_reg;
	assign ack = strobe_n || wcnt_reg >= waits;
	assign rdata = strobe_n ? ~{32'h0, cnt_reg} : {32'h0, first ? addr : cnt_reg};
	always_ff @(posedge clk_sys) begin
		act_reg <= !strobe_n;
		wcnt_reg <= strobe_n ? 4'h0 : wcnt_reg + 4'h1;
		if (!burst_n)
			in_burst_reg <= 1'b1;
		else if (strobe_n && act_reg)
			in_burst_reg <= 1'b0;
		if (first)
			cnt_reg <= addr;
		else if (strobe_n && act_reg)
			cnt_reg <= cnt_reg + 32'h1;
	end
endmodule // ebws_ext_mem

/* tb/ext_bus_burst_wait_suspend_tb.sv */
// self-checking bench for the external bus port
`timescale 1ns/10ps
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin fails++; \
	$display("MISMATCH %0t %h %h", $time, g, x); end end
`define WT(c) begin k = 0; while (!(c) && k < 60) begin @(negedge clk_sys); k++; end \
	if (k == 60) fails++; end
module ext_bus_burst_wait_suspend_tb;
	logic clk_sys, resetn, suspend_bus_hiz_n, core_req, core_write, core_last, core_sync;
	logic core_done, core_stall, host_sel, mem_req, mem_we, mem_ready, addr_oe, data_oe;
	logic bank_select_oe, read_strobe_n_o, read_strobe_oe, write_strobe_n_o, write_strobe_oe;
	logic burst_continue_n_o, burst_continue_oe, ack_o, ack_oe, m_ack, h_rd_n, h_burst_continue_n_n;
	logic [1:0] core_bank;
	logic [3:0] bank_select_n, waits;
	logic [31:0] core_addr, mem_addr, addr_o, h_addr, a;
	logic [63:0] core_wdata, core_rdata, mem_wdata, mem_rdata, data_o, data_i, e;
	logic [63:0] exq[$];
	int fails = 0, n_checks = 0, k;
	wire logic [2:0] multiproc_identifier = 3'h0;
	wire logic burst_driven = 1'b1;
	logic ack_driven = 1'b1;
	wire logic write_strobe_n_i = 1'b1;
	wire logic [31:0] addr_i = addr_oe ? addr_o : h_addr;
	wire logic read_strobe_n_i = read_strobe_oe ? read_strobe_n_o : h_rd_n;
	wire logic burst_continue_n_i = burst_continue_oe ? burst_continue_n_o : h_burst_continue_n_n;
	wire logic ack_i = ack_oe ? ack_o : (ack_driven ? m_ack : 1'b1);
	wire logic strb_n = read_strobe_n_i & (write_strobe_n_o | !write_strobe_oe);
	ebws_port uut (.*);
	ebws_ext_mem u_mem (.clk_sys, .waits, .strobe_n(strb_n), .burst_n(burst_continue_n_i),
		.addr(addr_i), .ack(m_ack), .rdata(data_i));
	task test_done;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic go(input logic w, input logic l, input logic [63:0] x);
		core_req = 1;
		core_write = w;
		core_last = l;
		core_wdata = {$urandom, $urandom};
		if (!w) exq.push_back(x);
		@(negedge clk_sys);
	endtask
	task automatic fin(input logic l);
		`WT(core_done === 1'b1)
		if (l) core_req = 0;
	endtask
	initial begin
		clk_sys = 0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		#120000;
		fails++;
		test_done;
	end
	// internal memory responder and result monitor
	always @(negedge clk_sys) begin
		mem_rdata <= {$urandom, $urandom};
		mem_ready <= mem_req === 1'b1 && !mem_ready;
		if (mem_req === 1'b1 && !mem_ready && exq.size() > 0) begin
			e = exq.pop_front();
			`CHK({32'h0, mem_addr}, e)
		end
		if (core_done === 1'b1 && exq.size() > 0) begin
			e = exq.pop_front();
			`CHK(core_rdata, e)
		end
		if (ack_oe === 1'b1 && ack_o === 1'b1 && host_sel === 1'b1)
			`CHK({data_oe, data_o}, {1'b1, mem_rdata})
	end
	initial begin
		{suspend_bus_hiz_n, h_rd_n, h_burst_continue_n_n} = 3'h7;
		{resetn, core_req, core_write, core_last, core_sync, host_sel, mem_ready} = 7'h0;
		{core_bank, waits, core_addr, h_addr} = 70'h0;
		core_wdata = 64'h0;
		mem_rdata = 64'h0;
		void'($urandom(32'ha1dfe51d));
		repeat (3) @(negedge clk_sys);
		resetn = 1;
		repeat (3) @(negedge clk_sys);
		for (int w = 0; w < 4; w++) begin
			waits = 4'(w);
			core_sync = w[0];
			core_bank = 2'(w);
			a = $urandom;
			core_addr = a;
			for (int i = 0; i < 3; i++) begin
				go(w > 1, i == 2, {32'h0, 32'(a + i)});
				fin(i == 2);
			end
			$display("burst %0d done", w);
			@(negedge clk_sys);
		end
		core_sync = 0;
		suspend_bus_hiz_n = 0;
		a = $urandom;
		core_addr = a;
		go(0, 1, {32'h0, a});
		repeat (5) @(negedge clk_sys);
		`CHK(core_stall, 1'b1)
		`CHK({addr_oe, data_oe, bank_select_oe, read_strobe_oe, core_done}, 5'h0)
		suspend_bus_hiz_n = 1;
		fin(1);
		$display("suspend done");
		@(negedge clk_sys);
		waits = 4'hf;
		a = $urandom;
		core_addr = a;
		go(0, 1, {32'h0, a});
		repeat (3) @(negedge clk_sys);
		ack_driven = 0;
		repeat (8) @(negedge clk_sys);
		`CHK(exq.size(), 1)
		ack_driven = 1;
		fin(1);
		$display("keeper done");
		@(negedge clk_sys);
		h_addr = $urandom;
		for (int i = 0; i < 3; i++) exq.push_back({32'h0, 32'(h_addr + i)});
		host_sel = 1;
		h_rd_n = 0;
		for (int i = 0; i < 3; i++) begin
			`WT(mem_req === 1'b1)
			h_burst_continue_n_n = i != 0;
			`WT((ack_oe & ack_o) === 1'b1)
			@(negedge clk_sys);
		end
		{host_sel, h_rd_n} = 2'h1;
		repeat (4) @(negedge clk_sys);
		`CHK(exq.size(), 0)
		$display("host burst done");
		test_done;
	end
endmodule // ext_bus_burst_wait_suspend_tb
